// ==== src/cirq_pkg.sv ====
// package: register map, field positions and types of the interrupt enable / arbitration capture block
package cirq_pkg;
   localparam logic [7:0] CIRQ_ADDR_FLAGS = 8'h03;
   localparam logic [7:0] CIRQ_ADDR_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] CIRQ_ADDR_ARB_POS = 8'h0B;
   localparam logic [7:0] CIRQ_ENABLE_RESET = 8'h00;
   localparam logic [4:0] CIRQ_POS_RESET = 5'h00;
   localparam int CIRQ_BUS_FAULT_BIT = 7;
   localparam int CIRQ_ARB_LOSS_BIT = 6;
   localparam int CIRQ_PASSIVE_BIT = 5;
   localparam int CIRQ_WAKE_BIT = 4;
   localparam int CIRQ_OVERRUN_BIT = 3;
   localparam int CIRQ_WARNING_BIT = 2;
   localparam int CIRQ_TX_DONE_BIT = 1;
   localparam int CIRQ_RX_AVAIL_BIT = 0;
   localparam int CIRQ_POS_WIDTH = 5;

   // register port of the host
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cirq_bus_t;

   // live status and event inputs from the protocol engine
   typedef struct packed {
      logic bus_error;
      logic arb_lost;
      logic [4:0] bit_pos;
      logic error_passive;
      logic wake_up;
      logic overrun_status;
      logic error_status;
      logic bus_status;
      logic tx_buf_released;
      logic rx_buf_full;
      logic bus_active;
      logic sleep_request;
   } cirq_evt_t;

   typedef enum logic [1:0] {
      CIRQ_ARMED = 2'b00,
      CIRQ_FROZEN = 2'b01
   } cirq_cap_t;
endpackage

// ==== src/cirq_edge.sv ====
// rise and change detector for level status inputs
`timescale 1ns/1ps
module cirq_edge
   import cirq_pkg::*;
#(
   parameter int WIDTH = 4
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] change
);
   logic [WIDTH-1:0] prev_r;

   // first cycle after reset sees no edge since prev starts cleared only if level is low
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         prev_r <= '0;
      else
         prev_r <= level;
   end

   assign rise = level & ~prev_r;
   assign change = level ^ prev_r;
endmodule

// ==== src/cirq_top.sv ====
// interrupt enable, pending flags and arbitration-loss position capture
`timescale 1ns/1ps
// How it works
// [R01] setting sleep while bus busy or interrupt pending raises the wake flag
// [R02] receive flag mirrors receive buffer full gated by its enable; read keeps it
// [R03] release command drops receive flag briefly; returns if more messages remain
// [R04] enable register at address 4, read and write
// [R05] enable bit 7 lets a bus error set its flag
// [R06] enable bit 6 lets arbitration loss set its flag
// [R07] enable bit 5 flags any change of error-passive state
// [R08] enable bit 4 flags leaving sleep
// [R09] enable bit 3 flags rising data overrun status
// [R10] enable bit 2 flags any change of error or bus status
// [R11] enable bit 1 flags transmit buffer released
// [R12] enable bit 0 flags receive buffer full
// [R13] clearing receive enable drops receive flag and interrupt at once
// [R14] capture register at address 11, read only, top three bits zero
// [R15] on arbitration loss capture five-bit position in same cycle
// [R16] captured position frozen until host reads capture register
// [R17] reading flag register clears arbitration flag
// [R18] no new arbitration flag until capture register read
// [R19] flag register at address 3, read clears all but receive flag
// [R20] interrupt asserted while any flag set
// [R21] captured value is binary frame bit number, 0 to 31
// [R22] interrupt output active low; reset clears enables and capture
module cirq_top
   import cirq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire cirq_bus_t bus,
   input wire cirq_evt_t evt,
   input wire logic rx_release,
   output logic [7:0] rdata,
   output logic irq_n,
   output logic sleep_accept
);
   logic [7:0] irq_enable_reg_r;
   logic [7:0] pending_flags_r;
   logic [7:0] pending_flags_nxt;
   logic [4:0] arb_pos_r;
   cirq_cap_t cap_state_r;
   logic rx_en_now;
   logic wr_enable;
   wire logic [7:0] src_req;
   wire logic [7:1] sticky_nxt;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] change;
   logic wake_rise;
   logic rd_flags;
   logic rd_pos;
   logic arb_take;
   logic [7:0] read_mux;

   // status levels whose edges raise flags
   assign lvl = {evt.error_passive, evt.overrun_status, evt.error_status, evt.bus_status};

   cirq_edge #(
      .WIDTH(4)
   ) u_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .level(lvl),
      .rise(rise),
      .change(change)
   );

   // one address match, shared by the strobe decodes and the read mux
   function automatic logic addr_hit(logic [7:0] addr, logic [7:0] target);
      addr_hit = (addr == target);
   endfunction

   assign rd_flags = bus.rd && addr_hit(bus.addr, CIRQ_ADDR_FLAGS);
   assign rd_pos = bus.rd && addr_hit(bus.addr, CIRQ_ADDR_ARB_POS);
   assign wr_enable = bus.wr && addr_hit(bus.addr, CIRQ_ADDR_IRQ_ENABLE); // see [R04]
   // a capture is allowed only while armed; re-arming needs a capture read
   assign arb_take = evt.arb_lost && (cap_state_r == CIRQ_ARMED); // see [R18]

   // wake flag: real wake-up, or a refused sleep request
   assign wake_rise = evt.wake_up
      || (evt.sleep_request && (evt.bus_active || (pending_flags_r != 8'h00))); // see [R01]

   // sleep is granted only with the bus idle and nothing pending
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         sleep_accept <= 1'b0;
      else
         sleep_accept <= evt.sleep_request && !evt.bus_active
            && (pending_flags_r == 8'h00); // see [R01]
   end

   // enable register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         irq_enable_reg_r <= CIRQ_ENABLE_RESET; // see [R22]
      else if (wr_enable)
         irq_enable_reg_r <= bus.wdata; // see [R04]
   end

   // event requests, one per flag bit
   assign src_req[CIRQ_BUS_FAULT_BIT] = evt.bus_error; // see [R05]
   assign src_req[CIRQ_ARB_LOSS_BIT] = arb_take; // see [R06] see [R15]
   assign src_req[CIRQ_PASSIVE_BIT] = change[3]; // see [R07]
   assign src_req[CIRQ_WAKE_BIT] = wake_rise; // see [R08]
   assign src_req[CIRQ_OVERRUN_BIT] = rise[2]; // see [R09]
   assign src_req[CIRQ_WARNING_BIT] = change[1] || change[0]; // see [R10]
   assign src_req[CIRQ_TX_DONE_BIT] = evt.tx_buf_released; // see [R11]
   // a release blanks the receive flag for one cycle only, the cycle after the release
   assign src_req[CIRQ_RX_AVAIL_BIT] = evt.rx_buf_full && !rx_release; // see [R12] see [R03]

   // sticky flags: an event in the clearing read cycle wins over the clear
   for (genvar i = 1; i < 8; i++)
   begin : g_sticky
      assign sticky_nxt[i] = (src_req[i] && irq_enable_reg_r[i])
         || (pending_flags_r[i] && !rd_flags); // see [R17] see [R19]
   end

   // a write to the enable register gates the receive flag at once, not a cycle later
   assign rx_en_now = wr_enable ? bus.wdata[CIRQ_RX_AVAIL_BIT]
      : irq_enable_reg_r[CIRQ_RX_AVAIL_BIT]; // see [R13]
   // receive flag is a live level, never sticky, so a flag read keeps it
   assign pending_flags_nxt = {sticky_nxt, src_req[CIRQ_RX_AVAIL_BIT] && rx_en_now}; // see [R02]

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pending_flags_r <= 8'h00;
      else
         pending_flags_r <= pending_flags_nxt;
   end

   // capture of the lost bit position
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cap_state_r <= CIRQ_ARMED; // see [R22]
         arb_pos_r <= CIRQ_POS_RESET;
      end
      else if (arb_take)
      begin
         cap_state_r <= CIRQ_FROZEN;
         arb_pos_r <= evt.bit_pos; // see [R15] see [R21]
      end
      else if (rd_pos)
         cap_state_r <= CIRQ_ARMED; // see [R16]
   end

   // read data, valid the cycle after the strobe
   always_comb
   begin
      if (addr_hit(bus.addr, CIRQ_ADDR_FLAGS))
         read_mux = pending_flags_r;
      else if (addr_hit(bus.addr, CIRQ_ADDR_IRQ_ENABLE))
         read_mux = irq_enable_reg_r; // see [R04]
      else if (addr_hit(bus.addr, CIRQ_ADDR_ARB_POS))
         read_mux = {3'h0, arb_pos_r}; // see [R14]
      else
         read_mux = 8'h00;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (bus.rd)
         rdata <= read_mux;
      else
         rdata <= 8'h00;
   end

   // fed from the next flags so the pin moves at the same edge as the flags
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         irq_n <= 1'b1; // see [R22]
      else
         irq_n <= (pending_flags_nxt == 8'h00); // see [R20] see [R13]
   end
endmodule

// ==== bench/cirq_top_sva.sv ====
// checker: port-level assertions for the interrupt enable and capture block
`timescale 1ns/1ps
module cirq_top_sva
   import cirq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire cirq_bus_t bus,
   input wire cirq_evt_t evt,
   input wire logic rx_release,
   input wire logic [7:0] rdata,
   input wire logic irq_n,
   input wire logic sleep_accept
);
   logic [7:0] en_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // shadow of the enable register, rebuilt from host writes
   always_ff @(posedge mclk)
      if (!rst_n)
         en_r <= 8'h00;
      else if (bus.wr && bus.addr == CIRQ_ADDR_IRQ_ENABLE)
         en_r <= bus.wdata;
   sequence s_rd(a); bus.rd && bus.addr == a; endsequence
   property p_en; s_rd(CIRQ_ADDR_IRQ_ENABLE) |=> rdata == $past(en_r); endproperty
   a_en: assert property (p_en) else $error("enable readback");
   property p_alc; s_rd(CIRQ_ADDR_ARB_POS) |=> rdata[7:5] == 3'h0; endproperty
   a_alc: assert property (p_alc) else $error("capture top bits");
   property p_berr; evt.bus_error && en_r[CIRQ_BUS_FAULT_BIT] |=> !irq_n; endproperty
   a_berr: assert property (p_berr) else $error("bus error irq");
   // a disabling write or a release in flight may drop the flag, so both are excluded
   property p_rx; evt.rx_buf_full && en_r[0] && !rx_release && !bus.wr |=> rx_release || !irq_n;
   endproperty
   a_rx: assert property (p_rx) else $error("receive irq");
   property p_rxk; bus.rd && bus.addr == CIRQ_ADDR_FLAGS && en_r[0] && !rx_release
      && $past(evt.rx_buf_full && en_r[0] && !rx_release) |=> rdata[0]; endproperty
   a_rxk: assert property (p_rxk) else $error("receive flag lost");
   property p_ali; s_rd(CIRQ_ADDR_FLAGS) ##0 !evt.arb_lost[*2] ##0 s_rd(CIRQ_ADDR_FLAGS)
      |=> !rdata[6]; endproperty
   a_ali: assert property (p_ali) else $error("arb flag kept");
   property p_irq; s_rd(CIRQ_ADDR_FLAGS) |=> (rdata != 8'h00) == !$past(irq_n); endproperty
   a_irq: assert property (p_irq) else $error("irq vs flags");
   property p_slp; evt.sleep_request |=> sleep_accept == $past(!evt.bus_active && irq_n);
   endproperty
   a_slp: assert property (p_slp) else $error("sleep accept");
endmodule
bind cirq_top cirq_top_sva chk (.mclk(mclk), .rst_n(rst_n), .bus(bus), .evt(evt),
   .rx_release(rx_release), .rdata(rdata), .irq_n(irq_n), .sleep_accept(sleep_accept));

// ==== bench/cirq_host.sv ====
// host model: one-cycle register strobes toward the block, or a two-cycle read strobe for a back-to-back read pair
`timescale 1ns/1ps
module cirq_host
   import cirq_pkg::*;
(
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output cirq_bus_t bus
);
   initial bus = '0;
   // read data is taken only in the cycle after the strobe
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      bus <= '{a, d, w, !w};
      @(posedge mclk);
      bus <= '0;
      #1 q = rdata;
   endtask
   // two reads of one address with no gap: the strobe simply stays up a second cycle
   task automatic acc2(logic [7:0] a, output logic [7:0] q1, output logic [7:0] q2);
      @(posedge mclk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      #1 q1 = rdata;
      @(posedge mclk);
      bus <= '0;
      #1 q2 = rdata;
   endtask
endmodule

// ==== bench/test_cirq_top.sv ====
// testbench: register and event scenarios for the interrupt block
`timescale 1ns/1ps
module test_cirq_top
   import cirq_pkg::*;
;
   localparam logic [7:0] FA = CIRQ_ADDR_FLAGS, EA = CIRQ_ADDR_IRQ_ENABLE, PA = CIRQ_ADDR_ARB_POS;
   logic mclk = 0, rst_n = 0, rx_release = 0, irq_n, sleep_accept;
   logic [7:0] rdata, q, q2;
   cirq_bus_t bus;
   cirq_evt_t evt = '0;
   int fail_count = 0, cmp_count = 0;
   always #12.5 mclk = ~mclk;
   cirq_host host (.mclk(mclk), .rdata(rdata), .bus(bus));
   cirq_top dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .evt(evt), .rx_release(rx_release),
      .rdata(rdata), .irq_n(irq_n), .sleep_accept(sleep_accept));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rr(logic [7:0] a, logic [7:0] e);
      host.acc(0, a, 8'h00, q);
      chk("rdata", e, q);
   endtask
   task automatic ww(logic [7:0] a, logic [7:0] d);
      host.acc(1, a, d, q);
   endtask
   // one cycle of a source picked by its flag bit (8: release, 0: sleep request), a level source toggled instead; position is wrong outside that cycle
   task automatic fire(int b, logic [4:0] p = 5'h00);
      @(posedge mclk);
      evt.bit_pos <= p;
      case (b)
         7: evt.bus_error <= 1;
         5: evt.error_passive <= !evt.error_passive;
         4: evt.wake_up <= 1;
         3: evt.overrun_status <= !evt.overrun_status;
         2: evt.error_status <= !evt.error_status;
         1: evt.tx_buf_released <= 1;
         6: evt.arb_lost <= 1;
         8: rx_release <= 1;
         default: evt.sleep_request <= 1;
      endcase
      @(posedge mclk);
      evt.bit_pos <= ~p;
      {evt.bus_error, evt.arb_lost, evt.wake_up, evt.tx_buf_released} <= '0;
      {evt.sleep_request, rx_release} <= '0;
      #1;
   endtask
   task automatic results;
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_n <= 1;
      rr(EA, CIRQ_ENABLE_RESET);
      rr(PA, 8'h00);
      rr(FA, 8'h00);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      ww(EA, 8'hA5);
      ww(PA, 8'hFF);
      ww(FA, 8'hFF);
      rr(EA, 8'hA5);
      rr(8'h20, 8'h00);
      rr(PA, 8'h00);
      for (int b = 1; b < 8; b++)
         if (b != 6)
         begin
            ww(EA, 8'h01 << b);
            fire(b);
            chk("irq_n", 8'h00, {7'h00, irq_n});
            rr(FA, 8'h01 << b);
            rr(FA, 8'h00);
            chk("irq_n", 8'h01, {7'h00, irq_n});
            ww(EA, 8'h00);
            fire(b);
            rr(FA, 8'h00);
         end
      ww(EA, 8'h40);
      fire(6, 5'h05);
      fire(6, 5'h09);
      rr(FA, 8'h40);
      fire(6, 5'h0C);
      rr(FA, 8'h00);
      rr(PA, 8'h05);
      fire(6, 5'h1F);
      host.acc2(FA, q, q2);
      chk("rdata", 8'h40, q);
      chk("rdata", 8'h00, q2);
      rr(PA, 8'h1F);
      ww(EA, 8'h01);
      @(posedge mclk);
      evt.rx_buf_full <= 1;
      rr(FA, 8'h01);
      rr(FA, 8'h01);
      ww(EA, 8'h00);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      ww(EA, 8'h01);
      fire(8);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      rr(FA, 8'h01);
      @(posedge mclk);
      evt.rx_buf_full <= 0;
      fire(8);
      rr(FA, 8'h00);
      ww(EA, 8'h10);
      @(posedge mclk);
      evt.bus_active <= 1;
      fire(0);
      chk("sleep_accept", 8'h00, {7'h00, sleep_accept});
      rr(FA, 8'h10);
      @(posedge mclk);
      evt.bus_active <= 0;
      fire(0);
      chk("sleep_accept", 8'h01, {7'h00, sleep_accept});
      results;
   end
   initial
   begin
      repeat (3000) @(posedge mclk);
      fail_count++;
      results;
   end
endmodule
